// [dpmbs_dev.sv]
// Behavioural dual-port memory seen from its left port, with mailbox and tokens.
// Assumes the bench plays the right port through the r_ tasks and r_sel/r_a.
`default_nettype none

module dpmbs_dev
    import dpmbs_pkg::*;
(
    input  wire logic              sel_n,
    input  wire logic              tok_n,
    input  wire logic              we_n,
    input  wire logic              oe_n,
    input  wire logic [1:0]        bn,
    input  wire logic [ADDR_W-1:0] a,
    input  wire logic [DATA_W-1:0] d,
    input  wire logic              master,
    input  wire logic [1:0]        b_oe,
    input  wire logic [1:0]        b_out_n,
    output logic      [DATA_W-1:0] q,
    output logic      [1:0]        busy_n,
    output logic                   irq_l_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Storage, flags and token latches
    // ----------------------------------------
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [7:0]        req [2];
    logic [1:0]        own [8];
    logic              irq_r_n, r_sel, tok_q, coll, blk;
    logic [ADDR_W-1:0] r_a;
    logic [DATA_W-1:0] last;
    logic [1:0]        pin;
    // Power-up state, tokens free
    initial begin
        req[0] = 8'hFF;
        req[1] = 8'hFF;
        foreach (own[i]) own[i] = 2'h0;
        {irq_l_n, irq_r_n, tok_q, r_sel} = 4'hE;
        r_a = '0;
        last = '0;
    end
    // Undriven busy pins float high
    assign pin = (b_oe & b_out_n) | ~b_oe;
    assign coll   = r_sel && !sel_n && a == r_a;
    assign busy_n = master ? {1'b1, !coll} : pin;
    assign blk = master ? coll : !(&pin);
    always @(negedge we_n) begin
        if (!sel_n && !blk) begin
            if (!bn[1]) mem[a][15:8] = d[15:8];
            if (!bn[0]) mem[a][7:0] = d[7:0];
            if (a == MBOX_RIGHT_ADDR) irq_r_n = 1'b0;
        end
        if (!tok_n) sem_wr(0, a[2:0], d[0]);
    end
    always @(negedge oe_n) begin
        if (!sel_n && a == MBOX_LEFT_ADDR) irq_l_n = 1'b1;
        if (!tok_n) tok_q = own[a[2:0]] != 2'h1;
    end
    // Released bus shows the inverse, so a late sample cannot pass by luck
    always @(oe_n or sel_n or a or tok_q) if (!oe_n) last = !sel_n ? mem[a] : {DATA_W{tok_q}};
    assign q = oe_n ? ~last : last;
    task automatic sem_wr(input int s, input logic [2:0] i, input logic v);
        req[s][i] = v;
        if (v && own[i] == 2'(s + 1)) own[i] = 2'h0;
        if (own[i] == 2'h0) own[i] = !req[0][i] ? 2'h1 : !req[1][i] ? 2'h2 : 2'h0;
    endtask
    function automatic logic r_tokrd(input logic [2:0] i);
        return own[i] != 2'h2;
    endfunction
    task automatic r_write(input logic [ADDR_W-1:0] ra, input logic [DATA_W-1:0] rd);
        mem[ra] = rd;
        if (ra == MBOX_LEFT_ADDR) irq_l_n = 1'b0;
    endtask
    task automatic r_read(input logic [ADDR_W-1:0] ra, output logic [DATA_W-1:0] rd);
        rd = mem[ra];
        if (ra == MBOX_RIGHT_ADDR) irq_r_n = 1'b1;
    endtask
endmodule // dpmbs_dev

`default_nettype wire

// [dpmbs_host.sv]
// Host controller for one port of a dual-port memory with mailbox,
// busy arbitration and token semaphores. Drives the port's pins.
// Assumes pins arrive asynchronously; user side is on ref_clk.
//
// Contract
// - In slave mode host holds busy high, or low to block writes.
// - Hold address and select until busy settles before write strobe.
// - Width expansion uses one master, slaves share its busy.
// - Depth expansion ANDs the parts' busy indications.
// - Claim token by writing zero, then read back to confirm.
`default_nettype none

module dpmbs_host
    import dpmbs_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic              port_is_left,
    input  wire logic              master_mode,
    input  wire logic              write_lock,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire dpmbs_op_t         cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] cmd_wdata,
    input  wire logic [1:0]        cmd_be,
    output logic                   rsp_valid,
    output logic                   rsp_ok,
    output logic      [DATA_W-1:0] rsp_rdata,
    output logic                   mail_pending,
    output logic                   port_select_n,
    output logic                   token_space_select_n,
    output logic                   write_strobe_n,
    output logic                   output_drive_n,
    output logic                   upper_byte_n,
    output logic                   lower_byte_n,
    output logic      [ADDR_W-1:0] mem_addr,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe,
    input  wire logic [1:0]        busy_in_n,
    output logic      [1:0]        busy_out_n,
    output logic      [1:0]        busy_oe,
    input  wire logic              mailbox_irq_n
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic op_writes(input dpmbs_op_t op, input logic ph);
        return (op == OP_WRITE) || (op == OP_TOK_FREE) || (op == OP_MBOX_SEND) ||
               ((op == OP_TOK_TAKE) && !ph);
    endfunction

    function automatic logic op_is_token(input dpmbs_op_t op);
        return (op == OP_TOK_TAKE) || (op == OP_TOK_FREE) || (op == OP_TOK_READ);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] data_s;
    logic [1:0]        busy_s_n;
    logic              irq_s_n;
    logic              busy_now;

    dpmbs_sync #(.W(DATA_W), .RESET_VAL(DATA_RESET)) u_data_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .pin_in   (data_in),
        .sync_out (data_s)
    );

    dpmbs_sync #(.W(3), .RESET_VAL(3'h7)) u_ctl_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .pin_in   ({mailbox_irq_n, busy_in_n}),
        .sync_out ({irq_s_n, busy_s_n})
    );

    // depth AND
    // Busy of either bank counts; only meaningful when the part is master
    assign busy_now     = master_mode && !(&busy_s_n);
    assign mail_pending = !irq_s_n;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    dpmbs_state_t      state_q, state_d;
    dpmbs_op_t         op_q, op_d;
    logic              phase_q, phase_d;
    logic              blocked_q, blocked_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic [CNT_W-1:0]  wait_q, wait_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0]        be_n_q, be_n_d;
    logic              sel_n_q, sel_n_d;
    logic              tok_n_q, tok_n_d;
    logic              rw_n_q, rw_n_d;
    logic              oe_n_q, oe_n_d;
    logic              doe_q, doe_d;
    logic              rsp_q, rsp_d;
    logic              ok_q, ok_d;
    logic [1:0]        bout_n_q, bout_n_d;
    logic [1:0]        boe_q, boe_d;

    assign cmd_ready = (state_q == ST_IDLE);

    // Next-state and pin decode; pins registered to keep them glitch-free
    always_comb begin
        state_d   = state_q;
        op_d      = op_q;
        phase_d   = phase_q;
        blocked_d = blocked_q;
        cnt_d     = cnt_q;
        wait_d    = wait_q;
        addr_d    = addr_q;
        wdata_d   = wdata_q;
        rdata_d   = rdata_q;
        be_n_d    = be_n_q;
        sel_n_d   = sel_n_q;
        tok_n_d   = tok_n_q;
        rw_n_d    = rw_n_q;
        oe_n_d    = oe_n_q;
        doe_d     = doe_q;
        rsp_d     = 1'b0;
        ok_d      = ok_q;
        // slave busy drive
        // Slave pins are held high, or low to lock out this port's writes
        boe_d     = master_mode ? 2'h0 : 2'h3;
        bout_n_d  = write_lock ? 2'h0 : 2'h3;
        case (state_q)
            ST_IDLE: begin
                if (cmd_valid) begin
                    op_d      = cmd_op;
                    phase_d   = 1'b0;
                    blocked_d = 1'b0;
                    wait_d    = '0;
                    cnt_d     = SETUP_CYC - 8'h01;
                    be_n_d    = ~cmd_be;
                    wdata_d   = cmd_wdata;
                    addr_d    = cmd_addr;
                    if (cmd_op == OP_MBOX_SEND) begin
                        addr_d = port_is_left ? MBOX_RIGHT_ADDR : MBOX_LEFT_ADDR;
                    end
                    if (cmd_op == OP_MBOX_ACK) begin
                        addr_d = port_is_left ? MBOX_LEFT_ADDR : MBOX_RIGHT_ADDR;
                    end
                    if (op_is_token(cmd_op)) begin
                        addr_d = {{(ADDR_W-TOKEN_SEL_W){1'b0}}, cmd_addr[TOKEN_SEL_W-1:0]};
                        be_n_d = 2'h0;
                        wdata_d = {DATA_W{cmd_op == OP_TOK_FREE}};
                    end
                    sel_n_d = op_is_token(cmd_op);
                    tok_n_d = !op_is_token(cmd_op);
                    doe_d   = op_writes(cmd_op, 1'b0);
                    state_d = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // settle before strobe
                // Address and select held while master busy settles and syncs
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (busy_now && !op_is_token(op_q)) begin
                    // stall the access; abort once wait_q reaches BUSY_WAIT_MAX
                    wait_d = wait_q + 8'h01;
                    if (wait_q == BUSY_WAIT_MAX) begin
                        blocked_d = 1'b1;
                        sel_n_d   = 1'b1;
                        doe_d     = 1'b0;
                        cnt_d     = RECOVER_CYC - 8'h01;
                        state_d   = ST_RECOVER;
                    end
                end else if (op_writes(op_q, phase_q)) begin
                    rw_n_d  = 1'b0;
                    cnt_d   = STROBE_CYC - 8'h01;
                    state_d = ST_STROBE;
                end else begin
                    // Read drive covers the data synchroniser latency
                    oe_n_d  = 1'b0;
                    cnt_d   = STROBE_CYC + SYNC_CYC - 8'h01;
                    state_d = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    if (!oe_n_q) begin
                        rdata_d = data_s;
                    end
                    // both selects high puts the port in standby
                    rw_n_d  = 1'b1;
                    oe_n_d  = 1'b1;
                    sel_n_d = 1'b1;
                    tok_n_d = 1'b1;
                    doe_d   = 1'b0;
                    cnt_d   = RECOVER_CYC - 8'h01;
                    state_d = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 8'h01;
                end else if ((op_q == OP_TOK_TAKE) && !phase_q) begin
                    phase_d = 1'b1;
                    tok_n_d = 1'b0;
                    cnt_d   = SETUP_CYC - 8'h01;
                    state_d = ST_SETUP;
                end else begin
                    rsp_d   = 1'b1;
                    if (op_q == OP_TOK_TAKE) begin
                        ok_d = !rdata_q[0];
                    end else begin
                        ok_d = !blocked_q &&
                               !(op_writes(op_q, 1'b0) && !master_mode && write_lock);
                    end
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (!ce) begin
            state_d = state_q;
            rsp_d   = rsp_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            op_q      <= OP_READ;
            phase_q   <= 1'b0;
            blocked_q <= 1'b0;
            cnt_q     <= '0;
            wait_q    <= '0;
            addr_q    <= ADDR_RESET;
            wdata_q   <= DATA_RESET;
            rdata_q   <= DATA_RESET;
            be_n_q    <= 2'h3;
            sel_n_q   <= 1'b1;
            tok_n_q   <= 1'b1;
            rw_n_q    <= 1'b1;
            oe_n_q    <= 1'b1;
            doe_q     <= 1'b0;
            rsp_q     <= 1'b0;
            ok_q      <= 1'b0;
            bout_n_q  <= 2'h3;
            boe_q     <= 2'h0;
        end else if (ce) begin
            state_q   <= state_d;
            op_q      <= op_d;
            phase_q   <= phase_d;
            blocked_q <= blocked_d;
            cnt_q     <= cnt_d;
            wait_q    <= wait_d;
            addr_q    <= addr_d;
            wdata_q   <= wdata_d;
            rdata_q   <= rdata_d;
            be_n_q    <= be_n_d;
            sel_n_q   <= sel_n_d;
            tok_n_q   <= tok_n_d;
            rw_n_q    <= rw_n_d;
            oe_n_q    <= oe_n_d;
            doe_q     <= doe_d;
            rsp_q     <= rsp_d;
            ok_q      <= ok_d;
            bout_n_q  <= bout_n_d;
            boe_q     <= boe_d;
        end
    end

    // Pin and response outputs straight from flops
    assign port_select_n        = sel_n_q;
    assign token_space_select_n = tok_n_q;
    assign write_strobe_n       = rw_n_q;
    assign output_drive_n       = oe_n_q;
    assign {upper_byte_n, lower_byte_n} = be_n_q;
    assign mem_addr             = addr_q;
    assign data_out             = wdata_q;
    assign data_oe              = doe_q;
    assign busy_out_n           = bout_n_q;
    assign busy_oe              = boe_q;
    assign rsp_valid            = rsp_q;
    assign rsp_ok               = ok_q;
    assign rsp_rdata            = rdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_write_after_settle: assert property (
        $fell(rw_n_q) |-> !$past(sel_n_q && tok_n_q, 1) && !$past(sel_n_q && tok_n_q, 3))
        else $error("write strobe before select settled");
    a_busy_gates_write: assert property (
        $fell(rw_n_q) && !sel_n_q |-> !$past(busy_now))
        else $error("memory write strobed while busy");
    a_slave_busy_drive: assert property (
        ce && !master_mode |=> boe_q == 2'h3 && bout_n_q == {2{!$past(write_lock)}})
        else $error("slave busy pins not driven");
    a_token_addr_low: assert property (
        !tok_n_q |-> addr_q[ADDR_W-1:TOKEN_SEL_W] == '0)
        else $error("token access with high address bits set");
    a_token_write_bit: assert property (
        !tok_n_q && !rw_n_q |-> doe_q && wdata_q[0] == (op_q == OP_TOK_FREE))
        else $error("token write data wrong");
    a_read_drops_sel: assert property (
        $rose(oe_n_q) |-> sel_n_q && tok_n_q ##1 sel_n_q && tok_n_q)
        else $error("selects held after read");
    a_take_reads_back: assert property (
        ce && state_q == ST_RECOVER && op_q == OP_TOK_TAKE && !phase_q && cnt_q == '0
        |=> ##3 !oe_n_q && !tok_n_q && rw_n_q)
        else $error("token request not read back");
    a_mbox_peer_addr: assert property (
        !rw_n_q && op_q == OP_MBOX_SEND |->
        addr_q == (port_is_left ? MBOX_RIGHT_ADDR : MBOX_LEFT_ADDR))
        else $error("mailbox send to wrong word");
    a_selects_exclusive: assert property (
        !(sel_n_q == 1'b0 && tok_n_q == 1'b0))
        else $error("memory and token selects both active");

    c_token_granted: cover property (rsp_valid && op_q == OP_TOK_TAKE && rsp_ok);
    c_busy_stall: cover property (state_q == ST_SETUP && busy_now && cnt_q == '0);
    c_mbox_send: cover property (!rw_n_q && op_q == OP_MBOX_SEND);
    c_mail_ack: cover property (rsp_valid && op_q == OP_MBOX_ACK);

endmodule // dpmbs_host

`default_nettype wire

// [dpmbs_pkg.sv]
// Shared constants and types for the dual-port memory host controller.
// Assumes a single 20 MHz clock domain; all counts are in ref_clk cycles.
`default_nettype none

package dpmbs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int BUSY_SETTLE_NS = 50;   // Select/address to busy valid
    localparam int STROBE_NS      = 100;  // Write pulse or read drive width
    localparam int RECOVER_NS     = 50;   // Selects high between accesses
    localparam int SYNC_STAGES    = 2;
    localparam int CNT_W          = 8;
    localparam logic [CNT_W-1:0] BUSY_SETTLE_CYC =
        CNT_W'((BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] STROBE_CYC =
        CNT_W'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RECOVER_CYC =
        CNT_W'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SYNC_CYC  = CNT_W'(SYNC_STAGES);
    localparam logic [CNT_W-1:0] SETUP_CYC = BUSY_SETTLE_CYC + SYNC_CYC;
    localparam logic [CNT_W-1:0] BUSY_WAIT_MAX = 8'hC8;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR  = 13'h1FFE;
    localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 13'h1FFF;
    localparam int TOKEN_SEL_W = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;

    // ------------------------------------------------------------
    // Commands and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ      = 3'h0,
        OP_WRITE     = 3'h1,
        OP_TOK_TAKE  = 3'h2,
        OP_TOK_FREE  = 3'h3,
        OP_TOK_READ  = 3'h4,
        OP_MBOX_SEND = 3'h5,
        OP_MBOX_ACK  = 3'h6
    } dpmbs_op_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_SETUP   = 2'h1,
        ST_STROBE  = 2'h2,
        ST_RECOVER = 2'h3
    } dpmbs_state_t;

endpackage

`default_nettype wire

// [dpmbs_sync.sv]
// Two-stage synchroniser for pin inputs.
// Assumes the pins are asynchronous to ref_clk; ce freezes the stages.
`default_nettype none

module dpmbs_sync #(
    parameter int          W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    // First stage feeds only the second one
    always_comb begin
        meta_d = ce ? pin_in : meta_q;
        sync_d = ce ? meta_q : sync_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule // dpmbs_sync

`default_nettype wire

// [tb_dual_port_mailbox_busy_semaphore.sv]
// Self-checking bench: host controller on the left port of a device model.
// Assumes dpmbs_pkg, dpmbs_host and dpmbs_dev are compiled before it.
`default_nettype none

module tb_dual_port_mailbox_busy_semaphore
    import dpmbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic              ref_clk, rst_n, master_mode, write_lock, cmd_valid, cmd_ready;
    logic              rsp_valid, rsp_ok, mail_pending, port_select_n, token_space_select_n;
    logic              write_strobe_n, output_drive_n, upper_byte_n, lower_byte_n, data_oe;
    logic              mailbox_irq_n, port_is_left;
    dpmbs_op_t         cmd_op;
    logic [ADDR_W-1:0] cmd_addr, mem_addr, ad;
    logic [DATA_W-1:0] cmd_wdata, rsp_rdata, data_in, data_out, v, e;
    logic [1:0]        cmd_be, busy_in_n, busy_out_n, busy_oe;
    int                failures, tests_run, seed;
    dpmbs_host dut (.ref_clk, .rst_n, .ce(1'b1), .port_is_left, .master_mode,
        .write_lock, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_be,
        .rsp_valid, .rsp_ok, .rsp_rdata, .mail_pending, .port_select_n,
        .token_space_select_n, .write_strobe_n, .output_drive_n, .upper_byte_n,
        .lower_byte_n, .mem_addr, .data_in, .data_out, .data_oe, .busy_in_n,
        .busy_out_n, .busy_oe, .mailbox_irq_n);
    // Data pin level: an undriven bus reads back inverted
    dpmbs_dev dev (.sel_n(port_select_n), .tok_n(token_space_select_n),
        .we_n(write_strobe_n), .oe_n(output_drive_n), .bn({upper_byte_n, lower_byte_n}),
        .a(mem_addr), .d(data_oe ? data_out : ~data_out), .master(master_mode),
        .b_oe(busy_oe), .b_out_n(busy_out_n), .q(data_in), .busy_n(busy_in_n),
        .irq_l_n(mailbox_irq_n));
    // 20 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // Compare, command and closing tasks
    // ----------------------------------------
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // One command, held until taken, then bounded wait for the response
    task automatic op(input dpmbs_op_t o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
        int n;
        @(negedge ref_clk);
        cmd_op = o;
        cmd_addr = a;
        cmd_wdata = w;
        cmd_valid = 1'b1;
        for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) @(negedge ref_clk);
        if (n == 300) begin
            failures++;
            $display("[FAIL] %0t command not taken", $time);
            wrap_up();
        end
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        for (n = 0; n < 300 && rsp_valid !== 1'b1; n++) @(negedge ref_clk);
        if (n == 300) begin
            failures++;
            $display("[FAIL] %0t response timeout", $time);
            wrap_up();
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 96317;
        {rst_n, cmd_valid, write_lock, master_mode, port_is_left} = 5'h03;
        cmd_op = OP_READ;
        {cmd_addr, cmd_wdata, cmd_be} = {13'h0000, 16'h0000, 2'h3};
        repeat (5) @(negedge ref_clk);
        chk({port_select_n, token_space_select_n, write_strobe_n, output_drive_n, data_oe},
            16'h001E);
        rst_n = 1'b1;
        // Random words, random byte lanes, read back on both ports
        for (int i = 0; i < 24; i++) begin
            ad = 13'($unsigned($random(seed))) & 13'h1FFD;
            v = 16'($random(seed));
            cmd_be = 2'h3;
            op(OP_WRITE, ad, 16'h0000);
            cmd_be = 2'($random(seed));
            op(OP_WRITE, ad, v);
            e = {cmd_be[1] ? v[15:8] : 8'h00, cmd_be[0] ? v[7:0] : 8'h00};
            cmd_be = 2'h3;
            op(OP_READ, ad, 16'h0000);
            chk(rsp_rdata, e);
            dev.r_read(ad, v);
            chk(v, e);
        end
        $display("test memory done");
        op(OP_MBOX_SEND, 13'h0000, 16'hBEEF);
        chk1(dev.irq_r_n, 1'b0);
        dev.r_read(MBOX_RIGHT_ADDR, v);
        chk(v, 16'hBEEF);
        chk1(dev.irq_r_n, 1'b1);
        dev.r_write(MBOX_LEFT_ADDR, 16'h1234);
        repeat (3) @(negedge ref_clk);
        chk1(mail_pending, 1'b1);
        op(OP_MBOX_ACK, 13'h0000, 16'h0000);
        chk(rsp_rdata, 16'h1234);
        repeat (3) @(negedge ref_clk);
        chk1(mail_pending, 1'b0);
        $display("test mailbox done");
        // Every token, random upper address bits
        for (int i = 0; i < 8; i++) begin
            ad = {10'($random(seed)), 3'(i)};
            op(OP_TOK_TAKE, ad, 16'h0000);
            chk1(rsp_ok, 1'b1);
            chk1(dev.r_tokrd(3'(i)), 1'b1);
            op(OP_TOK_FREE, ad ^ 13'h1FF8, 16'h0000);
            op(OP_TOK_READ, ad, 16'h0000);
            chk(rsp_rdata, 16'hFFFF);
        end
        // Contested token: refused, then granted on release
        dev.sem_wr(1, 3'h5, 1'b0);
        op(OP_TOK_TAKE, 13'h0005, 16'h0000);
        chk1(rsp_ok, 1'b0);
        dev.sem_wr(1, 3'h5, 1'b1);
        op(OP_TOK_READ, 13'h1FFD, 16'h0000);
        chk(rsp_rdata, 16'h0000);
        op(OP_TOK_FREE, 13'h0005, 16'h0000);
        $display("test tokens done");
        // Short collision stalls the write; persistent one aborts it
        ad = 13'h0100;
        dev.r_a = ad;
        dev.r_sel = 1'b1;
        fork
            begin
                repeat (20) @(negedge ref_clk);
                dev.r_sel = 1'b0;
            end
        join_none
        op(OP_WRITE, ad, 16'h5A5A);
        chk1(rsp_ok, 1'b1);
        dev.r_sel = 1'b1;
        op(OP_WRITE, ad, 16'h0F0F);
        chk1(rsp_ok, 1'b0);
        dev.r_sel = 1'b0;
        op(OP_READ, ad, 16'h0000);
        chk(rsp_rdata, 16'h5A5A);
        $display("test busy done");
        // Slave mode: host owns the busy pins
        master_mode = 1'b0;
        write_lock = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk({12'h000, busy_oe, busy_out_n}, 16'h000C);
        op(OP_WRITE, ad, 16'hC3C3);
        chk1(rsp_ok, 1'b0);
        write_lock = 1'b0;
        op(OP_WRITE, ad ^ 13'h0001, 16'h3C3C);
        op(OP_READ, ad, 16'h0000);
        chk(rsp_rdata, 16'h5A5A);
        dev.r_read(ad ^ 13'h0001, v);
        chk(v, 16'h3C3C);
        $display("test slave done");
        // Right-port role: the two mailbox words swap over
        port_is_left = 1'b0;
        op(OP_MBOX_SEND, 13'h0000, 16'hA55A);
        dev.r_read(MBOX_LEFT_ADDR, v);
        chk(v, 16'hA55A);
        op(OP_MBOX_ACK, 13'h0000, 16'h0000);
        chk(rsp_rdata, 16'hBEEF);
        $display("test right role done");
        wrap_up();
    end
endmodule // tb_dual_port_mailbox_busy_semaphore

`default_nettype wire
